// File: tedet_consts.svh
`ifndef TEDET_CONSTS_SVH
`define TEDET_CONSTS_SVH

// register offsets
`define TEDET_OFF_MCOUNT 8'h18
`define TEDET_OFF_CFG 8'h1d
`define TEDET_OFF_STATUS 8'h1e
`define TEDET_OFF_THS 8'h1f
`define TEDET_OFF_TCOUNT 8'h20
`define TEDET_OFF_SETUP 8'h30
`define TEDET_OFF_CTRL 8'h31

// reset values
`define TEDET_RST_CFG 5'h00
`define TEDET_RST_THS 8'h00
`define TEDET_RST_COUNT 8'h00
`define TEDET_RST_SETUP 8'h00
`define TEDET_RST_CTRL 1'h0

// configuration fields
`define TEDET_CFG_BYPASS 0
`define TEDET_CFG_EN_LO 1
`define TEDET_CFG_EN_HI 3
`define TEDET_CFG_LATCH 4
`define TEDET_CFG_W 5

// threshold fields
`define TEDET_THS_MODE 7
`define TEDET_THS_VAL_HI 6
`define TEDET_THS_LOWNOISE_MAX 7'h3f
`define TEDET_THS_SCALE_BITS 4

// status fields
`define TEDET_ST_EA 6

// setup fields
`define TEDET_SET_ODR_LO 0
`define TEDET_SET_ODR_HI 2
`define TEDET_SET_MODE_LO 3
`define TEDET_SET_MODE_HI 4
`define TEDET_SET_FS_LO 5
`define TEDET_SET_FS_HI 6
`define TEDET_SET_LOWNOISE 7

// debounce time base: 1.25 ms step, every other step a power of two of it
`define TEDET_CLK_PERIOD_NS 10
`define TEDET_BASE_STEP_US 1250
`define TEDET_SHIFT_800HZ 4'h0
`define TEDET_SHIFT_400HZ 4'h1
`define TEDET_SHIFT_200HZ 4'h2
`define TEDET_SHIFT_100HZ 4'h3
`define TEDET_SHIFT_50HZ 4'h4
`define TEDET_SHIFT_12HZ 4'h6
`define TEDET_SHIFT_6HZ 4'h7
`define TEDET_SHIFT_1HZ 4'h9
`define TEDET_CAP_NORMAL 4'h4
`define TEDET_CAP_LOW_POWER_LOW_NOISE_MODE 4'h6
`define TEDET_CAP_HIRES 4'h1
`define TEDET_CAP_LP 4'h7

`endif

// File: tedet_pkg.sv
package tedet_pkg;
    typedef enum logic [1:0] {
        TEDET_NORMAL,
        TEDET_LOW_POWER_LOW_NOISE_MODE,
        TEDET_HIRES,
        TEDET_LP
    } tedet_osmode_t;

    typedef enum logic [1:0] {
        TEDET_FS_2G,
        TEDET_FS_4G,
        TEDET_FS_8G,
        TEDET_FS_8G_ALT
    } tedet_range_t;
endpackage : tedet_pkg

// File: tedet_axis.sv
`include "tedet_consts.svh"

module tedet_axis #(
    parameter int DW = 12,
    parameter int CW = 8
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic step_i,
    input wire logic enable_i,
    input wire logic [DW-1:0] sample_i,
    input wire logic [1:0] shift_i,
    input wire logic [6:0] ths_i,
    input wire logic clear_mode_i,
    input wire logic [CW-1:0] count_i,
    output logic active_o,
    output logic pol_o
);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic active_ff;
    logic pol_ff;
    logic [DW-1:0] mag;
    logic [DW-1:0] scaled;
    logic [DW-1:0] ths_scaled;
    logic above;
    logic at_top;
    logic nxt_active;

    // magnitude rescaled to the 8 g range before comparing
    assign mag = sample_i[DW-1] ? DW'(~sample_i + 1'b1) : sample_i;
    assign scaled = mag >> shift_i;
    assign ths_scaled = {{(DW-7-`TEDET_THS_SCALE_BITS){1'b0}}, ths_i,
                         {`TEDET_THS_SCALE_BITS{1'b0}}};
    assign above = enable_i && (scaled > ths_scaled);
    assign at_top = cnt_ff >= count_i;

    always_comb begin
        if (above) begin
            nxt_cnt = at_top ? count_i : CW'(cnt_ff + 1'b1);
        end else if (clear_mode_i) begin
            nxt_cnt = '0;
        end else if (cnt_ff == '0) begin
            nxt_cnt = '0;
        end else begin
            nxt_cnt = CW'(cnt_ff - 1'b1);
        end
    end

    assign nxt_active = above && (nxt_cnt == count_i);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt_ff <= '0;
            active_ff <= 1'b0;
            pol_ff <= 1'b0;
        end else if (step_i) begin
            cnt_ff <= nxt_cnt;
            active_ff <= nxt_active;
            if (nxt_active) begin
                pol_ff <= sample_i[DW-1];
            end
        end
    end

    assign active_o = active_ff;
    assign pol_o = pol_ff;
endmodule : tedet_axis

// File: tedet_top.sv
//
// Function
// - eight-bit motion debounce count, resets zero
// - flag set when counter reaches count
// - counter saturates at programmed count
// - counter steps per sample, mode-dependent time
// - bypass bit selects unfiltered data
// - per-axis enables gate detection
// - latch enable bit; upper bits read zero
// - latched mode freezes status once active
// - status read clears bits and interrupt
// - latched-mode event bits never clear before read
// - status layout: zero, active, axis pairs
// - polarity bit records transient sign
// - seven-bit threshold, 0.063 g per step
// - low-noise limits threshold to 4 g
// - threshold bit seven selects counter mode
// - interrupt raised only when enabled
// - condition held for transient count samples
// - clear mode zeroes, other mode decrements
//
// Implementation choice: strobed register access.
`include "tedet_consts.svh"

module tedet_top #(
    parameter int DW = 12,
    parameter int BASE_STEP_CYCLES = `TEDET_BASE_STEP_US * 1000 / `TEDET_CLK_PERIOD_NS
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic SAMPLE_VALID_I,
    input wire logic [DW-1:0] RAW_X_I,
    input wire logic [DW-1:0] RAW_Y_I,
    input wire logic [DW-1:0] RAW_Z_I,
    input wire logic [DW-1:0] HPF_X_I,
    input wire logic [DW-1:0] HPF_Y_I,
    input wire logic [DW-1:0] HPF_Z_I,
    output logic TRANSIENT_EVENT_O,
    output logic [7:0] MOTION_COUNT_O
);
    localparam int NAX = 3;

    // registers
    logic [`TEDET_CFG_W-1:0] cfg_ff;
    logic [7:0] ths_ff;
    logic [7:0] tcount_ff;
    logic [7:0] mcount_ff;
    logic [7:0] setup_ff;
    logic ctrl_ff;
    logic [NAX-1:0] ev_ff;
    logic [NAX-1:0] pol_ff;
    logic ea_ff;
    logic [7:0] rdata_ff;
    logic event_ff;

    // held samples, one per axis
    logic [DW-1:0] raw_ff [NAX];
    logic [DW-1:0] hpf_ff [NAX];
    logic [DW-1:0] raw_in [NAX];
    logic [DW-1:0] hpf_in [NAX];

    // time base
    logic [23:0] base_cnt_ff;
    logic [9:0] sub_cnt_ff;
    logic [3:0] odr_shift;
    logic [3:0] cap_shift;
    logic [3:0] step_shift;
    logic [9:0] sub_top;
    logic base_tick;
    logic step_en;
    logic step_dly_ff;
    logic [2:0] odr_code;

    // decode
    logic wr_cfg;
    logic wr_ths;
    logic wr_tcount;
    logic wr_mcount;
    logic wr_setup;
    logic wr_ctrl;
    logic rd_status;
    logic [7:0] rd_mux;
    logic [7:0] status_word;

    // detection
    logic bypass;
    logic latch_en;
    logic clear_mode;
    logic [NAX-1:0] axis_en;
    logic [6:0] ths_eff;
    logic [1:0] fs_shift;
    tedet_pkg::tedet_osmode_t os_mode;
    tedet_pkg::tedet_range_t fs_range;
    logic [NAX-1:0] act;
    logic [NAX-1:0] apol;

    // status next state
    logic [NAX-1:0] base_ev;
    logic [NAX-1:0] base_pol;
    logic [NAX-1:0] nxt_ev;
    logic [NAX-1:0] nxt_pol;
    logic nxt_ea;
    logic hold_status;
    logic status_upd;

    // axis order in the arrays is x, y, z
    assign raw_in[0] = RAW_X_I;
    assign raw_in[1] = RAW_Y_I;
    assign raw_in[2] = RAW_Z_I;
    assign hpf_in[0] = HPF_X_I;
    assign hpf_in[1] = HPF_Y_I;
    assign hpf_in[2] = HPF_Z_I;

    // register decode
    // a write to the status offset matches no decode and is dropped
    assign wr_cfg = WR_I && (ADDR_I == `TEDET_OFF_CFG);
    assign wr_ths = WR_I && (ADDR_I == `TEDET_OFF_THS);
    assign wr_tcount = WR_I && (ADDR_I == `TEDET_OFF_TCOUNT);
    assign wr_mcount = WR_I && (ADDR_I == `TEDET_OFF_MCOUNT);
    assign wr_setup = WR_I && (ADDR_I == `TEDET_OFF_SETUP);
    assign wr_ctrl = WR_I && (ADDR_I == `TEDET_OFF_CTRL);
    assign rd_status = RD_I && (ADDR_I == `TEDET_OFF_STATUS);

    // configuration fields
    assign bypass = cfg_ff[`TEDET_CFG_BYPASS];
    assign axis_en = cfg_ff[`TEDET_CFG_EN_HI:`TEDET_CFG_EN_LO];
    assign latch_en = cfg_ff[`TEDET_CFG_LATCH];
    assign clear_mode = ths_ff[`TEDET_THS_MODE];
    assign os_mode = tedet_pkg::tedet_osmode_t'(setup_ff[`TEDET_SET_MODE_HI:`TEDET_SET_MODE_LO]);
    assign fs_range = tedet_pkg::tedet_range_t'(setup_ff[`TEDET_SET_FS_HI:`TEDET_SET_FS_LO]);

    // threshold ceiling drops to 4 g under low noise
    assign ths_eff = (setup_ff[`TEDET_SET_LOWNOISE]
                      && (ths_ff[`TEDET_THS_VAL_HI:0] > `TEDET_THS_LOWNOISE_MAX))
                     ? `TEDET_THS_LOWNOISE_MAX : ths_ff[`TEDET_THS_VAL_HI:0];

    // samples are brought to 8 g scale whatever the full-scale range
    always_comb begin
        case (fs_range)
            tedet_pkg::TEDET_FS_2G: fs_shift = 2'h2;
            tedet_pkg::TEDET_FS_4G: fs_shift = 2'h1;
            default: fs_shift = 2'h0;
        endcase
    end

    // step length from data rate, capped by the oversampling mode
    assign odr_code = setup_ff[`TEDET_SET_ODR_HI:`TEDET_SET_ODR_LO];

    always_comb begin
        case (odr_code)
            3'h0: odr_shift = `TEDET_SHIFT_800HZ;
            3'h1: odr_shift = `TEDET_SHIFT_400HZ;
            3'h2: odr_shift = `TEDET_SHIFT_200HZ;
            3'h3: odr_shift = `TEDET_SHIFT_100HZ;
            3'h4: odr_shift = `TEDET_SHIFT_50HZ;
            3'h5: odr_shift = `TEDET_SHIFT_12HZ;
            3'h6: odr_shift = `TEDET_SHIFT_6HZ;
            default: odr_shift = `TEDET_SHIFT_1HZ;
        endcase
    end

    always_comb begin
        case (os_mode)
            tedet_pkg::TEDET_NORMAL: cap_shift = `TEDET_CAP_NORMAL;
            tedet_pkg::TEDET_LOW_POWER_LOW_NOISE_MODE: cap_shift = `TEDET_CAP_LOW_POWER_LOW_NOISE_MODE;
            tedet_pkg::TEDET_HIRES: cap_shift = `TEDET_CAP_HIRES;
            default: cap_shift = `TEDET_CAP_LP;
        endcase
    end

    // a rate change mid-step ends that step at the first base tick with the sub count at or past the new top
    assign step_shift = (odr_shift > cap_shift) ? cap_shift : odr_shift;
    assign sub_top = 10'((10'h1 << step_shift) - 10'h1);
    assign base_tick = base_cnt_ff == 24'(BASE_STEP_CYCLES - 1);
    assign step_en = base_tick && (sub_cnt_ff >= sub_top);

    // base tick every 1.25 ms, stretched by the sub count to one step
    always_ff @(posedge CLK_I) begin
        if (!NRST_I || base_tick) begin
            base_cnt_ff <= 24'h0;
        end else begin
            base_cnt_ff <= 24'(base_cnt_ff + 24'h1);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I || step_en) begin
            sub_cnt_ff <= 10'h0;
        end else if (base_tick) begin
            sub_cnt_ff <= 10'(sub_cnt_ff + 10'h1);
        end
    end

    // axis flags change on the step edge; the status takes them one edge later
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            step_dly_ff <= 1'b0;
        end else begin
            step_dly_ff <= step_en;
        end
    end

    // per-axis sample hold and debounce
    genvar g;
    generate
        for (g = 0; g < NAX; g++) begin : g_axis
            always_ff @(posedge CLK_I) begin
                if (!NRST_I) begin
                    raw_ff[g] <= '0;
                    hpf_ff[g] <= '0;
                end else if (SAMPLE_VALID_I) begin
                    raw_ff[g] <= raw_in[g];
                    hpf_ff[g] <= hpf_in[g];
                end
            end

            // both copies are held so that a step always sees one whole sample
            tedet_axis #(
                .DW(DW),
                .CW(8)
            ) u_axis (
                .clk_i(CLK_I),
                .nrst_i(NRST_I),
                .step_i(step_en),
                .enable_i(axis_en[g]),
                .sample_i(bypass ? raw_ff[g] : hpf_ff[g]),
                .shift_i(fs_shift),
                .ths_i(ths_eff),
                .clear_mode_i(clear_mode),
                .count_i(tcount_ff),
                .active_o(act[g]),
                .pol_o(apol[g])
            );
        end
    endgenerate

    // status next value; a step that sets a flag wins over a read that clears
    assign base_ev = rd_status ? '0 : ev_ff;
    assign base_pol = rd_status ? '0 : pol_ff;
    assign hold_status = latch_en && ea_ff && !rd_status;
    assign status_upd = step_dly_ff && !hold_status;

    always_comb begin
        nxt_ev = base_ev;
        nxt_pol = base_pol;
        // live mode mirrors the axes, latched mode takes them at the first step with an active axis and holds them until a read
        if (status_upd) begin
            if (!latch_en) begin
                nxt_ev = act;
                nxt_pol = apol & act;
            end else begin
                nxt_ev = base_ev | act;
                nxt_pol = (apol & act) | (base_pol & ~act);
            end
        end else if (hold_status) begin
            nxt_ev = ev_ff;
            nxt_pol = pol_ff;
        end
    end

    assign nxt_ea = |nxt_ev;

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            ev_ff <= '0;
            pol_ff <= '0;
            ea_ff <= 1'b0;
            event_ff <= 1'b0;
        end else begin
            ev_ff <= nxt_ev;
            pol_ff <= nxt_pol;
            ea_ff <= nxt_ea;
            event_ff <= nxt_ea && ctrl_ff;
        end
    end

    // software registers
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            cfg_ff <= `TEDET_RST_CFG;
            ths_ff <= `TEDET_RST_THS;
            tcount_ff <= `TEDET_RST_COUNT;
            mcount_ff <= `TEDET_RST_COUNT;
            setup_ff <= `TEDET_RST_SETUP;
            ctrl_ff <= `TEDET_RST_CTRL;
        end else begin
            if (wr_cfg) begin
                cfg_ff <= WDATA_I[`TEDET_CFG_W-1:0];
            end
            if (wr_ths) begin
                ths_ff <= WDATA_I;
            end
            if (wr_tcount) begin
                tcount_ff <= WDATA_I;
            end
            if (wr_mcount) begin
                mcount_ff <= WDATA_I;
            end
            if (wr_setup) begin
                setup_ff <= WDATA_I;
            end
            if (wr_ctrl) begin
                ctrl_ff <= WDATA_I[0];
            end
        end
    end

    // read path; unmapped offsets read zero
    assign status_word = {1'b0, ea_ff, ev_ff[2], pol_ff[2], ev_ff[1], pol_ff[1],
                          ev_ff[0], pol_ff[0]};

    always_comb begin
        case (ADDR_I)
            `TEDET_OFF_CFG: rd_mux = {{(8-`TEDET_CFG_W){1'b0}}, cfg_ff};
            `TEDET_OFF_STATUS: rd_mux = status_word;
            `TEDET_OFF_THS: rd_mux = ths_ff;
            `TEDET_OFF_TCOUNT: rd_mux = tcount_ff;
            `TEDET_OFF_MCOUNT: rd_mux = mcount_ff;
            `TEDET_OFF_SETUP: rd_mux = setup_ff;
            `TEDET_OFF_CTRL: rd_mux = {7'h00, ctrl_ff};
            default: rd_mux = 8'h00;
        endcase
    end

    // read data stands for the one cycle after the strobe, zero otherwise
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= RD_I ? rd_mux : 8'h00;
        end
    end

    assign RDATA_O = rdata_ff;
    assign TRANSIENT_EVENT_O = event_ff;
    assign MOTION_COUNT_O = mcount_ff;
endmodule : tedet_top

// File: tedet_checker.sv
module tedet_checker (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic TRANSIENT_EVENT_O,
    input wire logic [7:0] MOTION_COUNT_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    logic [7:0] cfg_ff;
    logic [7:0] ths_ff;
    wire logic st_rd = RD_I && ADDR_I == 8'h1e;
    wire logic cnt_wr = WR_I && ADDR_I == 8'h18;
    wire logic [7:0] nxt_cfg = !NRST_I ? 8'h00 : (WR_I && ADDR_I == 8'h1d) ? WDATA_I : cfg_ff;
    wire logic [7:0] nxt_ths = !NRST_I ? 8'h00 : (WR_I && ADDR_I == 8'h1f) ? WDATA_I : ths_ff;
    // shadow copies of the config and threshold registers
    always_ff @(posedge CLK_I) begin
        cfg_ff <= nxt_cfg;
        ths_ff <= nxt_ths;
    end
    a_count_written: assert property (cnt_wr |=> MOTION_COUNT_O == $past(WDATA_I))
        else $error("motion count does not show the written value");
    a_count_held: assert property (!cnt_wr |=> $stable(MOTION_COUNT_O))
        else $error("motion count changed without a write");
    a_count_readback: assert property (
        RD_I && ADDR_I == 8'h18 |=> RDATA_O == MOTION_COUNT_O)
        else $error("motion count read back wrong");
    a_config_readback: assert property (
        RD_I && ADDR_I == 8'h1d |=> RDATA_O == {3'h0, cfg_ff[4:0]})
        else $error("config read back wrong");
    a_ths_readback: assert property (RD_I && ADDR_I == 8'h1f |=> RDATA_O == ths_ff)
        else $error("threshold read back wrong");
    a_status_top: assert property (st_rd |=> RDATA_O[7] == 1'b0)
        else $error("status top bit not zero");
    a_active_flags: assert property (
        $past(st_rd) |-> RDATA_O[6] == (RDATA_O[5] | RDATA_O[3] | RDATA_O[1]))
        else $error("event active disagrees with axis flags");
    a_event_active: assert property (
        $past(st_rd) && !RDATA_O[6] |-> !$past(TRANSIENT_EVENT_O))
        else $error("event output high without event active");
endmodule : tedet_checker

bind tedet_top tedet_checker u_checker (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .TRANSIENT_EVENT_O(TRANSIENT_EVENT_O),
    .MOTION_COUNT_O(MOTION_COUNT_O)
);

// File: tedet_tb_top.sv
module tedet_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int P0 = 4;
    typedef struct packed {
        logic [7:0] setup;
        logic [7:0] cfg;
        logic [7:0] ths;
        logic [35:0] hpf;
        logic [35:0] raw;
        logic [7:0] exp;
    } tedet_row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sv = 1'b0;
    logic [2:0][11:0] hpf = '0;
    logic [2:0][11:0] raw = '0;
    logic [7:0] rdata;
    logic ev;
    logic [7:0] mcount;
    int bad_count = 0;
    int num_checks = 0;
    logic [7:0] regs [8] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h18, 8'h30, 8'h31, 8'h05};
    tedet_row_t rows [9] = '{
        '{8'h40, 8'h0e, 8'h10, 36'heff100101, 36'h0, 8'h72},
        '{8'h40, 8'h0f, 8'h10, 36'h7ff7ff7ff, 36'h000e00000, 8'h4c},
        '{8'h40, 8'h02, 8'h10, 36'h7ff7ff7ff, 36'h0, 8'h42},
        '{8'h40, 8'h00, 8'h10, 36'h7ff7ff7ff, 36'h0, 8'h00},
        '{8'hc0, 8'h02, 8'h7f, 36'h0000003f1, 36'h0, 8'h42},
        '{8'h40, 8'h02, 8'h7f, 36'h0000003f1, 36'h0, 8'h00},
        '{8'h00, 8'h02, 8'h1f, 36'h0000007ff, 36'h0, 8'h42},
        '{8'h00, 8'h02, 8'h20, 36'h0000007ff, 36'h0, 8'h00},
        '{8'h20, 8'h02, 8'h3f, 36'h0000007e2, 36'h0, 8'h42}};

    always #5 clk = ~clk;

    tedet_top #(.DW(12), .BASE_STEP_CYCLES(P0)) u_dut (
        .CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .SAMPLE_VALID_I(sv), .RAW_X_I(raw[0]), .RAW_Y_I(raw[1]),
        .RAW_Z_I(raw[2]), .HPF_X_I(hpf[0]), .HPF_Y_I(hpf[1]), .HPF_Z_I(hpf[2]),
        .TRANSIENT_EVENT_O(ev), .MOTION_COUNT_O(mcount)
    );

    task automatic report_and_stop;
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    task automatic samp(input logic [35:0] h, input logic [35:0] r);
        @(posedge clk);
        sv <= 1'b1;
        hpf <= h;
        raw <= r;
        @(posedge clk);
        sv <= 1'b0;
    endtask : samp

    task automatic reset_dut;
        @(posedge clk);
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
    endtask : reset_dut

    task automatic hold_low(input int k);
        repeat (k) begin
            @(posedge clk);
            #1;
            chk({7'h0, ev}, 8'h00);
        end
    endtask : hold_low

    task automatic wait_ev(input logic want, input int lim);
        int n;
        n = 0;
        while (ev !== want) begin
            if (n == lim) begin
                chk({7'h0, ev}, {7'h0, want});
                report_and_stop();
            end
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_ev

    // count of four: three true steps, one false step, then true again
    task automatic debounce(input logic [7:0] setup, input logic clr, input int p);
        reset_dut();
        wr_reg(8'h30, setup);
        wr_reg(8'h31, 8'h01);
        wr_reg(8'h1d, 8'h02);
        wr_reg(8'h1f, {clr, 7'h10});
        wr_reg(8'h20, 8'h04);
        samp(36'h7ff, 36'h0);
        hold_low(3 * p - 2);
        samp(36'h0, 36'h0);
        hold_low(p - 2);
        samp(36'h7ff, 36'h0);
        if (clr) begin
            hold_low(2 * p + 2);
        end
        wait_ev(1'b1, 2 * p + 2);
        repeat (4 * p) @(posedge clk);
        samp(36'h0, 36'h0);
        wait_ev(1'b0, p + 2);
        if (!clr) begin
            samp(36'h7ff, 36'h0);
            wait_ev(1'b1, p + 2);
        end
    endtask : debounce

    initial begin
        reset_dut();
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        chk(mcount, 8'h00);
        wr_reg(8'h1d, 8'hff);
        rd_chk(8'h1d, 8'h1f);
        wr_reg(8'h1f, 8'h85);
        rd_chk(8'h1f, 8'h85);
        wr_reg(8'h18, 8'ha5);
        #1;
        chk(mcount, 8'ha5);
        rd_chk(8'h18, 8'ha5);
        wr_reg(8'h1e, 8'hff);
        rd_chk(8'h1e, 8'h00);
        foreach (rows[i]) begin
            reset_dut();
            wr_reg(8'h30, rows[i].setup);
            wr_reg(8'h31, 8'h01);
            wr_reg(8'h1d, rows[i].cfg);
            wr_reg(8'h1f, rows[i].ths);
            samp(rows[i].hpf, rows[i].raw);
            repeat (3 * P0) @(posedge clk);
            rd_chk(8'h1e, rows[i].exp);
            chk({7'h0, ev}, 8'h00);
        end
        debounce(8'h40, 1'b1, P0);
        debounce(8'h40, 1'b0, P0);
        debounce(8'h44, 1'b0, P0 * 16);
        debounce(8'h4d, 1'b1, P0 * 64);
        debounce(8'h54, 1'b0, P0 * 2);
        debounce(8'h5f, 1'b0, P0 * 128);
        debounce(8'h49, 1'b1, P0 * 2);
        debounce(8'h5a, 1'b0, P0 * 4);
        debounce(8'h43, 1'b1, P0 * 8);
        debounce(8'h5e, 1'b0, P0 * 128);
        reset_dut();
        wr_reg(8'h30, 8'h40);
        wr_reg(8'h31, 8'h01);
        wr_reg(8'h1d, 8'h16);
        wr_reg(8'h1f, 8'h10);
        samp(36'h101, 36'h0);
        wait_ev(1'b1, 2 * P0 + 2);
        samp(36'h200eff, 36'h0);
        repeat (3 * P0) @(posedge clk);
        rd_chk(8'h1e, 8'h42);
        repeat (2 * P0) @(posedge clk);
        samp(36'h0, 36'h0);
        repeat (3 * P0) @(posedge clk);
        rd_chk(8'h1e, 8'h4b);
        rd_chk(8'h1e, 8'h00);
        chk({7'h0, ev}, 8'h00);
        wr_reg(8'h31, 8'h00);
        samp(36'h101, 36'h0);
        hold_low(3 * P0);
        rd_chk(8'h1e, 8'h42);
        report_and_stop();
    end
endmodule : tedet_tb_top
